// >>> sfcs_seq.v
// serial flash command sequencer with mode 0 link master
`timescale 1ns/100ps
`include "sfcs_defines.vh"
module sfcs_seq #(
    parameter HALF = `SFCS_HALF_DIV,
    parameter GAP = `SFCS_GAP_CYC
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_cmd_valid,
    output wire o_cmd_ready,
    input wire [2:0] i_cmd,
    input wire [23:0] i_addr,
    input wire [15:0] i_len,
    input wire [12:0] i_region_blocks,
    input wire [7:0] i_wr_data,
    input wire i_wr_valid,
    output wire o_wr_ready,
    output reg [7:0] o_rd_data,
    output reg o_rd_valid,
    output reg [23:0] o_id,
    output reg [7:0] o_status,
    output reg o_done,
    output reg o_error,
    output wire o_busy,
    output reg o_sck,
    output reg o_cs_n,
    output reg o_mosi,
    input wire i_miso
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_WEN = 4'h1;
    localparam [3:0] S_WPOLL = 4'h2;
    localparam [3:0] S_CMD = 4'h3;
    localparam [3:0] S_ADR = 4'h4;
    localparam [3:0] S_DMY = 4'h5;
    localparam [3:0] S_DAT = 4'h6;
    localparam [3:0] S_BPOLL = 4'h7;
    localparam [3:0] S_GAP = 4'h8;
    localparam [3:0] S_FIN = 4'h9;
    localparam [7:0] HALF_M1 = HALF[7:0] - 8'h01;
    localparam [7:0] GAP_M1 = GAP[7:0] - 8'h01;
    // ****************************************
    // input synchroniser
    // ****************************************
    reg [1:0] miso_sync;
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            miso_sync <= 2'h0;
        end else begin
            miso_sync <= {miso_sync[0], i_miso};
        end
    end
    // ****************************************
    // byte shift engine
    // ****************************************
    reg eng_start;
    reg eng_busy;
    reg eng_done;
    reg [7:0] eng_tx;
    reg [7:0] shift;
    reg [7:0] rx;
    reg [2:0] bitn;
    reg [7:0] div;
    wire can_go = !eng_busy && !eng_done && !eng_start;
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            eng_busy <= 1'b0;
            eng_done <= 1'b0;
            shift <= 8'h00;
            rx <= 8'h00;
            bitn <= 3'h0;
            div <= 8'h00;
            o_sck <= 1'b0;
            o_mosi <= 1'b0;
        end else begin
            eng_done <= 1'b0;
            if (eng_start) begin
                eng_busy <= 1'b1;
                shift <= eng_tx;
                o_mosi <= eng_tx[7];
                bitn <= 3'h0;
                div <= 8'h00;
                o_sck <= 1'b0;
            end else if (eng_busy) begin
                div <= div + 8'h01;
                if (div == HALF_M1) begin
                    div <= 8'h00;
                    o_sck <= !o_sck;
                    if (o_sck) begin
                        rx <= {rx[6:0], miso_sync[1]};
                        if (bitn == 3'h7) begin
                            eng_busy <= 1'b0;
                            eng_done <= 1'b1;
                        end else begin
                            bitn <= bitn + 3'h1;
                            shift <= {shift[6:0], 1'b0};
                            o_mosi <= shift[6];
                        end
                    end
                end
            end
        end
    end
    // ****************************************
    // command decode
    // ****************************************
    reg [3:0] state;
    reg [3:0] ret;
    reg [2:0] cmd;
    reg [7:0] op;
    reg [23:0] cur_addr;
    reg [15:0] rem;
    reg [15:0] dcnt;
    reg [1:0] idx;
    reg [7:0] gcnt;
    wire need_len = (i_cmd == `SFCS_CMD_READ) ||
        (i_cmd == `SFCS_CMD_PROG) || (i_cmd == `SFCS_CMD_SFDP);
    wire need_reg = (i_cmd == `SFCS_CMD_READ) ||
        (i_cmd == `SFCS_CMD_PROG) || (i_cmd == `SFCS_CMD_SECT);
    wire in_reg = {1'b0, i_addr[23:12]} < i_region_blocks;
    wire bad = (need_len && (i_len == 16'h0000)) ||
        (need_reg && !in_reg);
    wire is_prog = (cmd == `SFCS_CMD_PROG);
    wire [8:0] room = `SFCS_PAGE_SIZE - {1'b0, cur_addr[7:0]};
    wire [15:0] lim = (room > 9'h0FF) ? `SFCS_PAGE_MAX : {7'h00, room};
    wire [15:0] chunk = (rem < lim) ? rem : lim;
    assign o_cmd_ready = (state == S_IDLE);
    assign o_busy = (state != S_IDLE);
    assign o_wr_ready = (state == S_DAT) && is_prog && can_go;
    // ****************************************
    // sequencer
    // ****************************************
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= S_IDLE;
            ret <= S_IDLE;
            cmd <= 3'h0;
            op <= 8'h00;
            cur_addr <= 24'h000000;
            rem <= 16'h0000;
            dcnt <= 16'h0000;
            idx <= 2'h0;
            gcnt <= 8'h00;
            eng_start <= 1'b0;
            eng_tx <= 8'h00;
            o_cs_n <= 1'b1;
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
            o_id <= 24'h000000;
            o_status <= 8'h00;
            o_done <= 1'b0;
            o_error <= 1'b0;
        end else begin
            eng_start <= 1'b0;
            o_done <= 1'b0;
            o_error <= 1'b0;
            o_rd_valid <= 1'b0;
            if (eng_start)
                o_cs_n <= 1'b0;
            case (state)
            S_IDLE: begin
                o_cs_n <= 1'b1;
                idx <= 2'h0;
                if (i_cmd_valid) begin
                    cmd <= i_cmd;
                    cur_addr <= i_addr;
                    rem <= i_len;
                    dcnt <= i_len;
                    if (bad) begin
                        o_done <= 1'b1;
                        o_error <= 1'b1;
                    end else begin
                        state <= S_CMD;
                        case (i_cmd)
                        `SFCS_CMD_ID: begin
                            op <= `SFCS_OP_ID;
                            dcnt <= `SFCS_ID_BYTES;
                        end
                        `SFCS_CMD_STAT: begin
                            op <= `SFCS_OP_STAT;
                            dcnt <= `SFCS_STAT_BYTES;
                        end
                        `SFCS_CMD_WREN: state <= S_WEN;
                        `SFCS_CMD_CHIP: begin
                            op <= `SFCS_OP_CHIP;
                            state <= S_WEN;
                        end
                        `SFCS_CMD_SECT: begin
                            op <= `SFCS_OP_SECT;
                            cur_addr <= {i_addr[23:12], 12'h000};
                            state <= S_WEN;
                        end
                        `SFCS_CMD_READ: op <= `SFCS_OP_READ;
                        `SFCS_CMD_PROG: begin
                            op <= `SFCS_OP_PROG;
                            state <= S_WEN;
                        end
                        default: op <= `SFCS_OP_SFDP;
                        endcase
                    end
                end
            end
            S_WEN: begin
                if (can_go) begin
                    eng_tx <= `SFCS_OP_WEN;
                    eng_start <= 1'b1;
                end else if (eng_done) begin
                    o_cs_n <= 1'b1;
                    ret <= S_WPOLL;
                    state <= S_GAP;
                end
            end
            S_WPOLL, S_BPOLL: begin
                if (can_go) begin
                    eng_tx <= (idx == 2'h0) ? `SFCS_OP_STAT : `SFCS_DUMMY;
                    eng_start <= 1'b1;
                end else if (eng_done) begin
                    idx <= {1'b0, ~idx[0]};
                    if (idx != 2'h0) begin
                        o_status <= rx;
                        o_cs_n <= 1'b1;
                        state <= S_GAP;
                        ret <= state;
                        if (state == S_WPOLL) begin
                            if (rx[`SFCS_ST_WEL]) begin
                                dcnt <= chunk;
                                ret <= (cmd == `SFCS_CMD_WREN) ? S_FIN : S_CMD;
                            end
                        end else if (!rx[`SFCS_ST_BUSY]) begin
                            ret <= (is_prog && rem != 16'h0000) ?
                                S_WEN : S_FIN;
                        end
                    end
                end
            end
            S_CMD: begin
                if (can_go) begin
                    eng_tx <= op;
                    eng_start <= 1'b1;
                end else if (eng_done) begin
                    if (cmd == `SFCS_CMD_ID || cmd == `SFCS_CMD_STAT) begin
                        state <= S_DAT;
                    end else if (cmd == `SFCS_CMD_CHIP) begin
                        o_cs_n <= 1'b1;
                        ret <= S_BPOLL;
                        state <= S_GAP;
                    end else begin
                        state <= S_ADR;
                    end
                end
            end
            S_ADR: begin
                if (can_go) begin
                    eng_start <= 1'b1;
                    case (idx)
                    2'h0: eng_tx <= cur_addr[23:16];
                    2'h1: eng_tx <= cur_addr[15:8];
                    default: eng_tx <= cur_addr[7:0];
                    endcase
                end else if (eng_done) begin
                    idx <= idx + 2'h1;
                    if (idx == 2'h2) begin
                        idx <= 2'h0;
                        if (cmd == `SFCS_CMD_SECT) begin
                            o_cs_n <= 1'b1;
                            ret <= S_BPOLL;
                            state <= S_GAP;
                        end else if (cmd == `SFCS_CMD_SFDP) begin
                            state <= S_DMY;
                        end else begin
                            state <= S_DAT;
                        end
                    end
                end
            end
            S_DMY: begin
                if (can_go) begin
                    eng_tx <= `SFCS_DUMMY;
                    eng_start <= 1'b1;
                end else if (eng_done)
                    state <= S_DAT;
            end
            S_DAT: begin
                if (can_go && (!is_prog || i_wr_valid)) begin
                    eng_tx <= is_prog ? i_wr_data : `SFCS_DUMMY;
                    eng_start <= 1'b1;
                end else if (eng_done) begin
                    dcnt <= dcnt - 16'h0001;
                    if (cmd == `SFCS_CMD_ID) begin
                        o_id <= {o_id[15:0], rx};
                    end else if (cmd == `SFCS_CMD_STAT) begin
                        o_status <= rx;
                    end else if (is_prog) begin
                        cur_addr <= cur_addr + 24'h000001;
                        rem <= rem - 16'h0001;
                    end else begin
                        o_rd_data <= rx;
                        o_rd_valid <= 1'b1;
                    end
                    if (dcnt == 16'h0001) begin
                        o_cs_n <= 1'b1;
                        ret <= is_prog ? S_BPOLL : S_FIN;
                        state <= S_GAP;
                    end
                end
            end
            S_GAP: begin
                o_cs_n <= 1'b1;
                gcnt <= gcnt + 8'h01;
                if (gcnt == GAP_M1) begin
                    gcnt <= 8'h00;
                    state <= ret;
                end
            end
            S_FIN: begin
                o_done <= 1'b1;
                state <= S_IDLE;
            end
            default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// >>> sfcs_defines.vh
// constants for the serial flash command sequencer
`ifndef SFCS_DEFINES_VH
`define SFCS_DEFINES_VH
// ****************************************
// flash opcodes
// ****************************************
`define SFCS_OP_ID 8'h9F
`define SFCS_OP_STAT 8'h05
`define SFCS_OP_WEN 8'h06
`define SFCS_OP_CHIP 8'hC7
`define SFCS_OP_READ 8'h03
`define SFCS_OP_PROG 8'h02
`define SFCS_OP_SECT 8'h20
`define SFCS_OP_SFDP 8'h5A
`define SFCS_DUMMY 8'h00
// ****************************************
// status byte fields
// ****************************************
`define SFCS_ST_BUSY 0
`define SFCS_ST_WEL 1
// ****************************************
// user command codes
// ****************************************
`define SFCS_CMD_ID 3'h0
`define SFCS_CMD_STAT 3'h1
`define SFCS_CMD_WREN 3'h2
`define SFCS_CMD_CHIP 3'h3
`define SFCS_CMD_SECT 3'h4
`define SFCS_CMD_READ 3'h5
`define SFCS_CMD_PROG 3'h6
`define SFCS_CMD_SFDP 3'h7
// ****************************************
// counts and timing
// ****************************************
`define SFCS_ID_BYTES 16'h0003
`define SFCS_STAT_BYTES 16'h0001
`define SFCS_PAGE_MAX 16'h00FF
`define SFCS_PAGE_SIZE 9'h100
`define SFCS_SECT_SHIFT 12
`define SFCS_HALF_DIV 4
`define SFCS_GAP_CYC 4
`endif

// >>> sfcs_seq_monitor.sv
// port assertions for the flash command sequencer
`timescale 1ns/100ps
`include "sfcs_defines.vh"
module sfcs_seq_mon #(
    parameter HALF = 4
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_cmd_valid,
    input wire o_cmd_ready,
    input wire [2:0] i_cmd,
    input wire [23:0] i_addr,
    input wire [15:0] i_len,
    input wire [12:0] i_region_blocks,
    input wire [7:0] o_status,
    input wire o_done,
    input wire o_error,
    input wire o_busy,
    input wire o_sck,
    input wire o_cs_n,
    input wire o_mosi
);
// ****************************************
// checks
// ****************************************
default clocking cb @(posedge i_ref_clk); endclocking
default disable iff (i_rst);
wire take = o_cmd_ready && i_cmd_valid;
wire rd_cmd = i_cmd == `SFCS_CMD_READ;
wire ad_cmd = rd_cmd || i_cmd == `SFCS_CMD_PROG || i_cmd == `SFCS_CMD_SECT;
reg [7:0] hi_n;
always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
        hi_n <= 8'h00;
    else
        hi_n <= o_sck ? hi_n + 8'h01 : 8'h00;
end
cs_idle_a: assert property (o_cmd_ready |-> o_cs_n)
    else $error("select low while idle");
gap_hold_a: assert property ($rose(o_cs_n) |=> o_cs_n[*4])
    else $error("select gap too short");
ready_idle_a: assert property (o_cmd_ready != o_busy)
    else $error("ready and busy disagree");
sck_low_a: assert property (o_cs_n |-> !o_sck)
    else $error("clock high while deselected");
mosi_hold_a: assert property (o_sck |-> $stable(o_mosi))
    else $error("data moved while clock high");
sck_half_a: assert property ($fell(o_sck) |-> hi_n == HALF)
    else $error("clock high phase wrong");
done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
done_idle_a: assert property (o_done && !o_error |-> !o_status[0])
    else $error("done while flash busy");
err_done_a: assert property (o_error |-> o_done)
    else $error("error without done");
len_refuse_a: assert property (take && rd_cmd && i_len == 16'h0000
    |=> o_done && o_error) else $error("empty read not refused");
region_refuse_a: assert property (take && ad_cmd
    && {1'b0, i_addr[23:12]} >= i_region_blocks |=> o_done && o_error)
    else $error("out of region not refused");
endmodule

// >>> sfcs_flash_model.sv
// behavioural serial flash on the far side of the link
`timescale 1ns/100ps
module sfcs_flash_model #(
    parameter [23:0] ID = 24'h000000,
    parameter POLLS = 3
) (
    input wire i_sck,
    input wire i_cs_n,
    input wire i_mosi,
    output reg o_miso
);
// ****************************************
// memory window of 64 bytes, address wraps
// ****************************************
reg [7:0] mem [0:63];
reg [7:0] sh, op, out;
reg [23:0] adr, eadr, paddr;
reg wel = 1'b0;
integer nb, bc, nlast, busy = 0, nprog = 0, i;
initial begin
    o_miso = 1'b0;
    for (i = 0; i < 64; i = i + 1)
        mem[i] = 8'h00;
end
always @(negedge i_cs_n) begin
    nb = 0;
    bc = 0;
end
always @(posedge i_sck) if (!i_cs_n) begin
    sh = {sh[6:0], i_mosi};
    bc = bc + 1;
    if (bc == 8) begin
        bc = 0;
        if (nb == 0)
            op = sh;
        else if (nb < 4)
            adr = {adr[15:0], sh};
        else if (op == 8'h02) begin
            mem[adr[5:0]] = sh;
            adr = adr + 24'h000001;
        end
        nb = nb + 1;
        if (nb == 4)
            paddr = adr;
        case (op)
            8'h9F: out = nb == 1 ? ID[23:16] : nb == 2 ? ID[15:8] : ID[7:0];
            8'h05: out = {6'h00, wel, busy != 0};
            8'h03: if (nb >= 4) begin
                out = mem[adr[5:0]];
                adr = adr + 24'h000001;
            end
            8'h5A: if (nb >= 5) begin
                out = ~adr[7:0];
                adr = adr + 24'h000001;
            end
            default: out = 8'hA5;
        endcase
    end
end
always @(negedge i_sck) if (!i_cs_n) begin
    o_miso = out[7];
    out = {out[6:0], out[7]};
end
always @(posedge i_cs_n) begin
    nlast = nb;
    o_miso = ~o_miso;
    if (op == 8'h06)
        wel = 1'b1;
    if (op == 8'h05 && busy > 0)
        busy = busy - 1;
    if (wel && (op == 8'hC7 || op == 8'h20 || op == 8'h02)) begin
        busy = POLLS;
        wel = 1'b0;
        eadr = adr;
        if (op == 8'h02)
            nprog = nprog + 1;
        if (op == 8'hC7)
            for (i = 0; i < 64; i = i + 1)
                mem[i] = 8'hFF;
    end
end
endmodule

// >>> sfcs_seq_tb_top.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/100ps
`include "sfcs_defines.vh"
module sfcs_seq_tb_top;
localparam [23:0] FID = 24'h5A3C96; // arbitrary identity value
reg i_ref_clk = 1'b0;
reg i_rst = 1'b1;
reg i_cmd_valid = 1'b0;
reg [2:0] i_cmd = 3'h0;
reg [23:0] i_addr = 24'h000000;
reg [15:0] i_len = 16'h0000;
reg [12:0] i_region_blocks = 13'h0002;
reg [7:0] i_wr_data = 8'h40;
reg i_wr_valid = 1'b0;
wire o_cmd_ready, o_wr_ready, o_rd_valid, o_done, o_error, o_busy;
wire o_sck, o_cs_n, o_mosi, i_miso;
wire [7:0] o_rd_data, o_status;
wire [23:0] o_id;
integer fails = 0;
integer cmp_count = 0;
integer j;
reg [7:0] rxq [$];
always #20 i_ref_clk = ~i_ref_clk;
sfcs_seq u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .i_cmd(i_cmd),
    .i_addr(i_addr), .i_len(i_len), .i_region_blocks(i_region_blocks),
    .i_wr_data(i_wr_data), .i_wr_valid(i_wr_valid), .o_wr_ready(o_wr_ready),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_id(o_id),
    .o_status(o_status), .o_done(o_done), .o_error(o_error), .o_busy(o_busy),
    .o_sck(o_sck), .o_cs_n(o_cs_n), .o_mosi(o_mosi), .i_miso(i_miso));
sfcs_flash_model #(.ID(FID)) u_flash (.i_sck(o_sck), .i_cs_n(o_cs_n),
    .i_mosi(o_mosi), .o_miso(i_miso));
always @(posedge i_ref_clk) begin
    if (o_rd_valid)
        rxq.push_back(o_rd_data);
    if (o_wr_ready && i_wr_valid)
        i_wr_data <= i_wr_data + 8'h01;
end
// ****************************************
// shared tasks
// ****************************************
task test_done;
begin
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
task check(input [23:0] seen, input [23:0] exp);
begin
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
end
endtask
task run(input [2:0] c, input [23:0] a, input [15:0] n, input e);
    integer k;
begin
    rxq.delete();
    @(posedge i_ref_clk);
    i_cmd <= c;
    i_addr <= a;
    i_len <= n;
    i_cmd_valid <= 1'b1;
    i_wr_valid <= c == `SFCS_CMD_PROG;
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    k = 0;
    #1;
    while (o_done !== 1'b1 && k < 40000) begin
        @(posedge i_ref_clk);
        #1;
        k = k + 1;
    end
    if (k == 40000) begin
        fails = fails + 1;
        test_done;
    end else begin
        check(o_error, e);
    end
end
endtask
// ****************************************
// scenarios
// ****************************************
task t_id;
begin
    run(`SFCS_CMD_ID, 24'h000000, 16'h0000, 1'b0);
    check(o_id, FID);
    check(u_flash.nlast, 24'h000004);
end
endtask
task t_stat;
begin
    run(`SFCS_CMD_STAT, 24'h000000, 16'h0000, 1'b0);
    check(o_status, 24'h000000);
    check(u_flash.nlast, 24'h000002);
end
endtask
task t_wren;
begin
    run(`SFCS_CMD_WREN, 24'h000000, 16'h0000, 1'b0);
    check(o_status[1], 1'b1);
    check(u_flash.wel, 1'b1);
end
endtask
task t_sect;
begin
    run(`SFCS_CMD_SECT, 24'h001ABC, 16'h0000, 1'b0);
    check(u_flash.eadr, 24'h001000);
    check(u_flash.busy, 24'h000000);
end
endtask
task t_prog;
begin
    run(`SFCS_CMD_PROG, 24'h0000F0, 16'h0014, 1'b0);
    check(u_flash.nprog, 24'h000002);
    check(u_flash.paddr, 24'h000100);
    run(`SFCS_CMD_READ, 24'h0000F0, 16'h0014, 1'b0);
    check(rxq.size(), 24'h000014);
    for (j = 0; j < 20; j = j + 1)
        check(rxq[j], 8'h40 + j[7:0]);
end
endtask
task t_chip;
begin
    run(`SFCS_CMD_CHIP, 24'h000000, 16'h0000, 1'b0);
    check(u_flash.busy, 24'h000000);
    run(`SFCS_CMD_READ, 24'h000000, 16'h0004, 1'b0);
    for (j = 0; j < 4; j = j + 1)
        check(rxq[j], 8'hFF);
end
endtask
task t_sfdp;
begin
    run(`SFCS_CMD_SFDP, 24'h000010, 16'h0002, 1'b0);
    check(rxq.size(), 24'h000002);
    for (j = 0; j < 2; j = j + 1)
        check(rxq[j], {~(8'h10 + j[7:0])});
end
endtask
task t_refuse;
begin
    run(`SFCS_CMD_READ, 24'h000000, 16'h0000, 1'b1);
    run(`SFCS_CMD_PROG, 24'h002000, 16'h0001, 1'b1);
    run(`SFCS_CMD_SECT, 24'h003000, 16'h0000, 1'b1);
    check(u_flash.nprog, 24'h000002);
end
endtask
initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_id;
    t_stat;
    t_wren;
    t_sect;
    t_prog;
    t_chip;
    t_sfdp;
    t_refuse;
    test_done;
end
endmodule
bind sfcs_seq sfcs_seq_mon #(.HALF(HALF)) u_mon (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
    .i_cmd(i_cmd), .i_addr(i_addr), .i_len(i_len),
    .i_region_blocks(i_region_blocks), .o_status(o_status),
    .o_done(o_done), .o_error(o_error), .o_busy(o_busy), .o_sck(o_sck),
    .o_cs_n(o_cs_n), .o_mosi(o_mosi));
